// File: logic/nsc_pkg.sv
// Package of constants and types for the nibble strobe and calibration controller.
`default_nettype none
package nsc_pkg;
	// --------------------------------------------------------------------
	// Timing and reset values
	// --------------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 25;
	localparam logic [5:0] READ_IDLE_RST = 6'h00;
	localparam logic [7:0] ROUNDING_RST = 8'h10;
	// Calibration sweep length, in core clocks, of the initial delay calibration.
	localparam logic [7:0] CAL_CYCLES = 8'h40;
	// Drift tracking update interval, in core clocks.
	localparam logic [7:0] TRACK_INTERVAL = 8'h20;

	// --------------------------------------------------------------------
	// Encodings
	// --------------------------------------------------------------------
	localparam logic DIV_BY_TWO = 1'b0;
	localparam logic DIV_BY_FOUR = 1'b1;
	localparam logic SRC_SYNTH = 1'b0;
	localparam logic SRC_REF = 1'b1;

	// Calibration sequencer states, Gray coded along the usual path.
	typedef enum logic [1:0] {
		NSC_IDLE = 2'b00,
		NSC_CAL = 2'b01,
		NSC_READY = 2'b11
	} nsc_cal_e;
endpackage : nsc_pkg
`default_nettype wire

// File: logic/nsc_ctrl.sv
// Nibble strobe gating, termination hold, clock division and calibration control.
`timescale 1ns/1ps
`default_nettype none

// Contract
// R1 - Gated strobe passes only from preamble onward.
// R2 - Block strobe after each fall, reopen later.
// R3 - Gating exists only in slice zero.
// R4 - Gate follows read window enable input.
// R5 - Idle count delays termination switch off.
// R6 - Eight-bit deserialization uses divide by four.
// R7 - Four-bit uses divide by two; write clock divided.
// R8 - Synthesizer clock option is default source.
// R9 - Reference clock source only for receive slices.
// R10 - Rounding factor power of two, default sixteen.
// R11 - Control port clock always external.
// R12 - Calibration enabled runs initial calibration.
// R13 - Calibration disabled skips initial calibration.
// R14 - Input delays tracked for drift when enabled.
// R15 - Output delays tracked for drift when enabled.
// R16 - Quarter delays tracked when enabled.
// R17 - Delay calibrated flag after initial calibration.
module nsc_ctrl (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic rx_gating_enable,
	input wire logic strobe_pin,
	input wire logic read_window_enable,
	input wire logic [5:0] read_idle_count,
	input wire logic div_mode,
	input wire logic master_clock_select,
	input wire logic is_receive_slice,
	input wire logic [7:0] rounding_factor,
	input wire logic builtin_self_calibration,
	input wire logic input_delay_drift_track,
	input wire logic output_delay_drift_track,
	input wire logic quarter_delay_drift_track,
	output logic slice_zero_strobe,
	output logic odt_enable,
	output logic fifo_write_clock_out,
	output logic source_is_reference,
	output logic config_error,
	output logic delay_calibrated_flag,
	output logic input_delay_update,
	output logic output_delay_update,
	output logic quarter_delay_update
);
	// --------------------------------------------------------------------
	// Input synchronisers
	// --------------------------------------------------------------------
	logic [1:0] stb_sync_r;
	logic [1:0] stb_sync_nxt;
	logic [1:0] rwe_sync_r;
	logic [1:0] rwe_sync_nxt;
	logic stb_d_r;
	logic stb_d_nxt;

	// The pin strobe and read window both come from outside, so two stages each.
	always_comb
	begin
		stb_sync_nxt = {stb_sync_r[0], strobe_pin};
		rwe_sync_nxt = {rwe_sync_r[0], read_window_enable};
		stb_d_nxt = stb_sync_r[1];
	end

	// Synchroniser registers.
	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			stb_sync_r <= 2'h0;
			rwe_sync_r <= 2'h0;
			stb_d_r <= 1'b0;
		end
		else
		begin
			stb_sync_r <= stb_sync_nxt;
			rwe_sync_r <= rwe_sync_nxt;
			stb_d_r <= stb_d_nxt;
		end
	end

	// --------------------------------------------------------------------
	// Slice zero strobe gate and termination hold
	// --------------------------------------------------------------------
	logic gate_open_r;
	logic gate_open_nxt;
	logic blank_r;
	logic blank_nxt;
	logic strobe_out_r;
	logic strobe_out_nxt;
	logic [5:0] idle_cnt_r;
	logic [5:0] idle_cnt_nxt;
	logic odt_r;
	logic odt_nxt;
	logic stb_fall;

	// Only slice zero receives a strobe, so this is the single gate of the nibble. [R3]
	always_comb
	begin
		stb_fall = stb_d_r & ~stb_sync_r[1];
		gate_open_nxt = rwe_sync_r[1]; // [R4]
		// Blank for one cycle after each falling edge, then reopen. [R2]
		blank_nxt = stb_fall;
		if (!rx_gating_enable)
			strobe_out_nxt = stb_sync_r[1];
		else
			strobe_out_nxt = stb_sync_r[1] & gate_open_r & ~blank_r; // [R1]
		// Termination stays on for the idle count after the read window closes. [R5]
		idle_cnt_nxt = idle_cnt_r;
		odt_nxt = odt_r;
		if (rwe_sync_r[1])
		begin
			odt_nxt = 1'b1;
			idle_cnt_nxt = read_idle_count;
		end
		else if (idle_cnt_r != 6'h00)
			idle_cnt_nxt = idle_cnt_r - 6'h01;
		else
			odt_nxt = 1'b0;
	end

	// Gate and termination registers.
	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			gate_open_r <= 1'b0;
			blank_r <= 1'b0;
			strobe_out_r <= 1'b0;
			idle_cnt_r <= nsc_pkg::READ_IDLE_RST;
			odt_r <= 1'b0;
		end
		else
		begin
			gate_open_r <= gate_open_nxt;
			blank_r <= blank_nxt;
			strobe_out_r <= strobe_out_nxt;
			idle_cnt_r <= idle_cnt_nxt;
			odt_r <= odt_nxt;
		end
	end

	assign slice_zero_strobe = strobe_out_r;
	assign odt_enable = odt_r;

	// --------------------------------------------------------------------
	// Write clock divider and source checks
	// --------------------------------------------------------------------
	logic [1:0] div_cnt_r;
	logic [1:0] div_cnt_nxt;
	logic wclk_r;
	logic wclk_nxt;
	logic src_ref_r;
	logic src_ref_nxt;
	logic cfg_err_r;
	logic cfg_err_nxt;
	logic pow2_ok;

	// Divide by two toggles every cycle, divide by four every second cycle. [R6] [R7]
	always_comb
	begin
		div_cnt_nxt = div_cnt_r + 2'h1;
		wclk_nxt = wclk_r;
		if (div_mode == nsc_pkg::DIV_BY_TWO)
			wclk_nxt = ~wclk_r;
		else if (div_cnt_r[0])
			wclk_nxt = ~wclk_r;
		// Reference source is legal only on a receive slice. [R8] [R9]
		src_ref_nxt = (master_clock_select == nsc_pkg::SRC_REF);
		// Flag a rounding factor that is not one bit set. [R10]
		pow2_ok = (rounding_factor != 8'h00) &&
			((rounding_factor & (rounding_factor - 8'h01)) == 8'h00);
		cfg_err_nxt = ~pow2_ok | (src_ref_nxt & ~is_receive_slice);
	end

	// Divider and configuration registers; control port clock is external only. [R11]
	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			div_cnt_r <= 2'h0;
			wclk_r <= 1'b0;
			src_ref_r <= nsc_pkg::SRC_SYNTH;
			cfg_err_r <= 1'b0;
		end
		else
		begin
			div_cnt_r <= div_cnt_nxt;
			wclk_r <= wclk_nxt;
			src_ref_r <= src_ref_nxt;
			cfg_err_r <= cfg_err_nxt;
		end
	end

	assign fifo_write_clock_out = wclk_r;
	assign source_is_reference = src_ref_r;
	assign config_error = cfg_err_r;

	// --------------------------------------------------------------------
	// Calibration sequencer and drift tracking
	// --------------------------------------------------------------------
	nsc_pkg::nsc_cal_e cal_st_r;
	nsc_pkg::nsc_cal_e cal_st_nxt;
	logic [7:0] cal_cnt_r;
	logic [7:0] cal_cnt_nxt;
	logic [7:0] trk_cnt_r;
	logic [7:0] trk_cnt_nxt;
	logic trk_tick;

	// After reset the sequencer calibrates, or skips straight to ready when disabled.
	always_comb
	begin
		cal_st_nxt = cal_st_r;
		cal_cnt_nxt = cal_cnt_r;
		case (cal_st_r)
			nsc_pkg::NSC_IDLE:
			begin
				cal_cnt_nxt = 8'h00;
				if (builtin_self_calibration)
					cal_st_nxt = nsc_pkg::NSC_CAL; // [R12]
				else
					cal_st_nxt = nsc_pkg::NSC_READY; // [R13]
			end
			nsc_pkg::NSC_CAL:
			begin
				cal_cnt_nxt = cal_cnt_r + 8'h01;
				if (cal_cnt_r == nsc_pkg::CAL_CYCLES - 8'h01)
					cal_st_nxt = nsc_pkg::NSC_READY; // [R17]
			end
			default:
				cal_st_nxt = nsc_pkg::NSC_READY;
		endcase
		// Tracking updates only run once calibrated, to avoid disturbing the sweep.
		trk_tick = (cal_st_r == nsc_pkg::NSC_READY) && (trk_cnt_r == 8'h00);
		if (cal_st_r != nsc_pkg::NSC_READY || trk_cnt_r == 8'h00)
			trk_cnt_nxt = nsc_pkg::TRACK_INTERVAL - 8'h01;
		else
			trk_cnt_nxt = trk_cnt_r - 8'h01;
	end

	// Calibration registers.
	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			cal_st_r <= nsc_pkg::NSC_IDLE;
			cal_cnt_r <= 8'h00;
			trk_cnt_r <= 8'h00;
		end
		else
		begin
			cal_st_r <= cal_st_nxt;
			cal_cnt_r <= cal_cnt_nxt;
			trk_cnt_r <= trk_cnt_nxt;
		end
	end

	// Per-path drift update pulses.
	assign input_delay_update = trk_tick & input_delay_drift_track; // [R14]
	assign output_delay_update = trk_tick & output_delay_drift_track; // [R15]
	assign quarter_delay_update = trk_tick & quarter_delay_drift_track; // [R16]
	assign delay_calibrated_flag = (cal_st_r == nsc_pkg::NSC_READY); // [R17]
endmodule : nsc_ctrl

`default_nettype wire

// File: bench/nsc_far_end.sv
// Far-side model: strobe source and fabric read window driver.
`timescale 1ns/1ps
`default_nettype none
module nsc_far_end (
	input wire logic core_clk,
	input wire logic run,
	input wire logic win,
	output logic strobe_pin = 1'b0,
	output logic read_window_enable = 1'b0
);
	logic [1:0] ph_r = 2'h0;
	// Strobe bursts three high, one low; it rests low between bursts like a real source.
	// The lone low cycle makes the high after each fall fall into the blanking slot.
	always @(posedge core_clk)
	begin
		ph_r <= run ? ph_r + 2'h1 : 2'h0;
		strobe_pin <= run & (ph_r != 2'h2);
		read_window_enable <= win;
	end
endmodule : nsc_far_end
`default_nettype wire

// File: bench/nsc_ctrl_assertions.sv
// Concurrent checks on the controller ports.
`timescale 1ns/1ps
`default_nettype none
module nsc_ctrl_assertions (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic rx_gating_enable,
	input wire logic strobe_pin,
	input wire logic read_window_enable,
	input wire logic div_mode,
	input wire logic master_clock_select,
	input wire logic is_receive_slice,
	input wire logic builtin_self_calibration,
	input wire logic input_delay_drift_track,
	input wire logic output_delay_drift_track,
	input wire logic slice_zero_strobe,
	input wire logic odt_enable,
	input wire logic fifo_write_clock_out,
	input wire logic source_is_reference,
	input wire logic config_error,
	input wire logic delay_calibrated_flag,
	input wire logic input_delay_update,
	input wire logic output_delay_update
);
	// One domain, so clock and reset are given once.
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst);
	chk_cal_skip: assert property ($fell(rst) && !builtin_self_calibration |=>
		delay_calibrated_flag) else $error("flag late with calibration off");
	chk_cal_wait: assert property ($fell(rst) && builtin_self_calibration |=>
		!delay_calibrated_flag ##[60:70] delay_calibrated_flag) else $error("calibration time");
	chk_flag_hold: assert property (delay_calibrated_flag |=>
		delay_calibrated_flag) else $error("ready flag dropped");
	chk_div_two: assert property ((!div_mode)[*4] |->
		fifo_write_clock_out != $past(fifo_write_clock_out)) else $error("divide_by_two clock");
	chk_div_four: assert property ((div_mode)[*6] |->
		fifo_write_clock_out != $past(fifo_write_clock_out, 2)) else $error("divide_by_four clock");
	chk_src_follow: assert property ($stable(master_clock_select)[*3] |->
		source_is_reference == master_clock_select) else $error("source report");
	chk_cfg_bad: assert property ((master_clock_select && !is_receive_slice)[*3] |->
		config_error) else $error("reference on transmit slice not flagged");
	chk_gate_shut: assert property ((rx_gating_enable && !read_window_enable)[*6] |->
		!slice_zero_strobe) else $error("strobe leaked through closed gate");
	chk_blank_fall: assert property ($past(rx_gating_enable) && $past(strobe_pin, 5) &&
		!$past(strobe_pin, 4) |-> !slice_zero_strobe) else $error("strobe not blanked after fall");
	chk_pass_thru: assert property ((!rx_gating_enable)[*4] |->
		slice_zero_strobe == $past(strobe_pin, 3)) else $error("ungated strobe path");
	chk_upd_ready: assert property (input_delay_update |->
		delay_calibrated_flag && input_delay_drift_track ##1 !input_delay_update)
		else $error("input update pulse");
	chk_upd_period: assert property (output_delay_update |->
		##32 (output_delay_update || !output_delay_drift_track)) else $error("output period");
	chk_odt_hold: assert property (read_window_enable[*4] ##1 !read_window_enable |->
		odt_enable) else $error("termination dropped early");
endmodule : nsc_ctrl_assertions
bind nsc_ctrl nsc_ctrl_assertions u_chk (.core_clk, .rst, .rx_gating_enable, .strobe_pin,
	.read_window_enable, .div_mode, .master_clock_select, .is_receive_slice,
	.builtin_self_calibration, .input_delay_drift_track, .output_delay_drift_track,
	.slice_zero_strobe, .odt_enable, .fifo_write_clock_out, .source_is_reference,
	.config_error, .delay_calibrated_flag, .input_delay_update, .output_delay_update);
`default_nettype wire

// File: bench/nsc_ctrl_tb.sv
// Self-checking bench for the nibble strobe and calibration controller.
`timescale 1ns/1ps
`default_nettype none
module nsc_ctrl_tb;
	logic core_clk = 1'b0;
	logic rst = 1'b1;
	logic gate_en = 1'b0, run = 1'b0, win = 1'b0, div = 1'b0, sel = 1'b0, rx_sl = 1'b1;
	logic cal = 1'b1;
	logic [5:0] idle = 6'h00;
	logic [7:0] rnd = nsc_pkg::ROUNDING_RST;
	logic [2:0] trk = 3'h7;
	logic strb, rwe, szs, odt, fwc, sref, cerr, rdy;
	logic [2:0] upd;
	int bad_count = 0, tests_run = 0, cyc = 0;
	nsc_far_end far (.core_clk, .run, .win, .strobe_pin(strb), .read_window_enable(rwe));
	nsc_ctrl dut (.core_clk, .rst, .rx_gating_enable(gate_en), .strobe_pin(strb),
		.read_window_enable(rwe), .read_idle_count(idle), .div_mode(div),
		.master_clock_select(sel), .is_receive_slice(rx_sl), .rounding_factor(rnd),
		.builtin_self_calibration(cal), .input_delay_drift_track(trk[0]),
		.output_delay_drift_track(trk[1]), .quarter_delay_drift_track(trk[2]),
		.slice_zero_strobe(szs), .odt_enable(odt), .fifo_write_clock_out(fwc),
		.source_is_reference(sref), .config_error(cerr), .delay_calibrated_flag(rdy),
		.input_delay_update(upd[0]), .output_delay_update(upd[1]),
		.quarter_delay_update(upd[2]));
	// Clock, and a cycle ceiling well above the roughly 530 cycles the run needs.
	// The control port is clocked from this external clock alone.
	initial forever #(nsc_pkg::CLK_PERIOD_NS / 2.0) core_clk = ~core_clk;
	always @(posedge core_clk)
	begin
		cyc <= cyc + 1;
		if (cyc == 5000)
		begin
			bad_count++;
			test_done();
		end
	end
	task automatic test_done;
		$display("checks %0d mismatches %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : test_done
	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		tests_run++;
		if (got !== exp)
		begin
			bad_count++;
			$display("FAIL %s expected %0h seen %0h", what, exp, got);
		end
	endtask : chk
	task automatic tick(input int n);
		repeat (n) @(posedge core_clk);
	endtask : tick
	// Counts edges that see the signal high, stopping at the first low.
	task automatic run_len(ref logic s, output int n);
		n = 0;
		while (s === 1'b1 && n < 300)
		begin
			tick(1);
			n++;
		end
	endtask : run_len
	task automatic cnt_high(ref logic s, output int n);
		n = 0;
		repeat (16)
		begin
			tick(1);
			n += int'(s === 1'b1);
		end
	endtask : cnt_high
	// Reset for eight cycles, then time the ready flag from release.
	task automatic do_reset(input logic c);
		int n;
		cal <= c;
		rst <= 1'b1;
		tick(8);
		rst <= 1'b0;
		n = 0;
		do
		begin
			tick(1);
			n++;
		end
		while (rdy !== 1'b1 && n < 200);
		chk("ready", c ? nsc_pkg::CAL_CYCLES + 8'h01 : 8'h01, 8'(n - 1));
	endtask : do_reset
	task automatic t_div(input logic d);
		int n;
		div <= d;
		tick(8);
		while (fwc !== 1'b0)
			tick(1);
		while (fwc !== 1'b1)
			tick(1);
		run_len(fwc, n);
		chk("div", d ? 8'h02 : 8'h01, 8'(n));
	endtask : t_div
	// Entries are {select, receive, rounding, expected reference, expected error}.
	task automatic t_cfg;
		logic [11:0] tbl [6] = '{12'h440, 12'hc42, 12'h843, 12'h40d, 12'h600, 12'h404};
		foreach (tbl[i])
		begin
			{sel, rx_sl, rnd} <= tbl[i][11:2];
			tick(4);
			chk("cfg", {6'h00, tbl[i][1:0]}, {6'h00, sref, cerr});
		end
		{sel, rx_sl, rnd} <= {2'b01, nsc_pkg::ROUNDING_RST};
	endtask : t_cfg
	task automatic t_gate;
		int n;
		gate_en <= 1'b1;
		run <= 1'b1;
		tick(8);
		cnt_high(szs, n);
		chk("gate_shut", 8'h00, 8'(n));
		win <= 1'b1;
		tick(8);
		cnt_high(szs, n);
		chk("gate_open", 8'h08, 8'(n));
		gate_en <= 1'b0;
		win <= 1'b0;
		tick(8);
		cnt_high(szs, n);
		chk("gate_off", 8'h0c, 8'(n));
		run <= 1'b0;
	endtask : t_gate
	task automatic t_odt(input logic [5:0] c, output int n);
		idle <= c;
		win <= 1'b1;
		tick(10);
		win <= 1'b0;
		tick(1);
		run_len(odt, n);
		tick(4);
	endtask : t_odt
	// Any 96 cycles after ready hold exactly three pulses of each enabled update.
	task automatic t_trk(input logic [2:0] t);
		int n [3];
		trk <= t;
		tick(2);
		n = '{0, 0, 0};
		repeat (96)
		begin
			tick(1);
			foreach (n[i]) n[i] += int'(upd[i] === 1'b1);
		end
		foreach (n[i]) chk("upd", t[i] ? 8'h03 : 8'h00, 8'(n[i]));
	endtask : t_trk
	// Main sequence.
	initial
	begin
		int n0;
		int n1;
		do_reset(1'b1);
		t_div(nsc_pkg::DIV_BY_FOUR);
		t_div(nsc_pkg::DIV_BY_TWO);
		t_cfg();
		t_gate();
		t_odt(6'h00, n0);
		t_odt(6'h05, n1);
		chk("odt", 8'h05, 8'(n1 - n0));
		t_odt(6'h3f, n1);
		chk("odt", 8'h3f, 8'(n1 - n0));
		t_trk(3'h7);
		t_trk(3'h2);
		do_reset(1'b0);
		test_done();
	end
endmodule : nsc_ctrl_tb
`default_nettype wire
